// ---- src/frc_feeder_reclose.sv ----
// feeder trip, close, target, reclosing, group and breaker monitor logic
`default_nettype none
// ==========================================================================
// Overview of operation
// - trip is OR of selected row 1,2,4,6 bits, direct trip or open command
// - aux 1 and 2 are OR of selected bits from rows 1 to 4
// - aux 3 is OR of selected bits from rows 1,3,4,6
// - aux 4 ORs rows 2,3,4,6 bits, or acts as alarm when configured
// - close asserts from recloser, direct close input or close command
// - alarm asserts on any self-test warning or failure
// - close-in target set at trip unless row 1 was up past target delay
// - at trip, latch phase target for each phase above phase pickup
// - at trip, latch negseq and residual targets above their pickups
// - reset lamp in reset state, held open lamp in lockout
// - four shots, each with its own open interval, plus reset interval
// - reset timer held cleared while row 1 up, restarts on dropout
// - permit off forces lockout, sets final open bit, blocks autoclose
// - no permit input means permit true; zero first interval disables
// - shots allowed equal count of leading nonzero open intervals, up to four
// - shot flag asserts when current shot bit set in mask, msb is shot 0
// - cancel on selected rows, permit off, direct trip, close fail, open
// - downstream step term pulse while closed and untripped advances shot in reset and closing states
// - six groups each with own logic, selected by inputs or command
// - every breaker trip counted as relay or external, unless a reset command comes in the same cycle
// - per-pole interrupted current sums per trip class
// - reset command clears trip counts and current sums
// - exactly one of reset, cycling and lockout state bits asserted
// - close fail status asserts on detected close failure
module frc_feeder_reclose
  import frc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // protection element word rows
  input wire logic [ROW_W-1:0] row1,
  input wire logic [ROW_W-1:0] row2,
  input wire logic [ROW_W-1:0] row3,
  input wire logic [ROW_W-1:0] row4,
  input wire logic [ROW_W-1:0] row6,
  // per-group selection masks, one entry per group, rows concatenated
  input wire logic [NUM_GROUPS*5*ROW_W-1:0] trip_mask,
  input wire logic [NUM_GROUPS*4*ROW_W-1:0] aux1_mask,
  input wire logic [NUM_GROUPS*4*ROW_W-1:0] aux2_mask,
  input wire logic [NUM_GROUPS*4*ROW_W-1:0] aux3_mask,
  input wire logic [NUM_GROUPS*4*ROW_W-1:0] aux4_mask,
  input wire logic [NUM_GROUPS*4*ROW_W-1:0] cancel_mask,
  input wire logic [NUM_GROUPS*ROW_W-1:0] step_mask,
  input wire logic [NUM_GROUPS-1:0] aux4_alarm_mode,
  // per-group timer settings in power-system cycles, shot mask and current pickups
  input wire logic [NUM_GROUPS*SHOTS*TMR_W-1:0] open_interval,
  input wire logic [NUM_GROUPS*TMR_W-1:0] reset_interval,
  input wire logic [NUM_GROUPS*TMR_W-1:0] instant_target_delay,
  input wire logic [NUM_GROUPS*TMR_W-1:0] close_fail_time,
  input wire logic [NUM_GROUPS*5-1:0] shot_mask,
  input wire logic [NUM_GROUPS*CUR_W-1:0] phase_pickup,
  input wire logic [NUM_GROUPS*CUR_W-1:0] negseq_pickup,
  input wire logic [NUM_GROUPS*CUR_W-1:0] residual_pickup,
  // measured currents
  input wire logic [CUR_W-1:0] ia,
  input wire logic [CUR_W-1:0] ib,
  input wire logic [CUR_W-1:0] ic,
  input wire logic [CUR_W-1:0] i_negseq,
  input wire logic [CUR_W-1:0] i_residual,
  // control inputs and commands
  input wire logic direct_trip_input,
  input wire logic direct_close_input,
  input wire logic autoclose_permit_input,
  input wire logic permit_assigned,
  input wire logic group_select_1,
  input wire logic group_select_2,
  input wire logic group_select_3,
  input wire logic group_inputs_used,
  input wire logic group_cmd,
  input wire logic [GRP_W-1:0] group_cmd_value,
  input wire logic open_cmd,
  input wire logic open_cmd_enable,
  input wire logic close_cmd,
  input wire logic target_reset_cmd,
  input wire logic breaker_reset_cmd,
  input wire logic selftest_warn,
  input wire logic selftest_fail,
  input wire logic breaker_aux_status,
  // output contacts
  output logic trip_output,
  output logic close_output,
  output logic aux_output_1,
  output logic aux_output_2,
  output logic aux_output_3,
  output logic aux_output_4,
  output logic alarm_output,
  // targets and status
  output logic close_in_fault_lamp,
  output logic [2:0] phase_lamp,
  output logic negseq_lamp,
  output logic residual_lamp,
  output logic reset_state_lamp,
  output logic held_open_lamp,
  output logic cycling_state_bit,
  output logic final_open_state_bit,
  output logic shot_flag_bit,
  output logic [2:0] shot_count,
  output logic close_fail,
  output logic [GRP_W-1:0] active_group,
  // breaker monitor
  output logic [CNT_W-1:0] relay_trip_count,
  output logic [CNT_W-1:0] ext_trip_count,
  output logic [3*SUM_W-1:0] relay_current_sum,
  output logic [3*SUM_W-1:0] ext_current_sum
);

  // ========================================================================
  // setting group selection
  logic [GRP_W-1:0] group_r;
  wire [GRP_W-1:0] pin_group = {group_select_3, group_select_2, group_select_1};
  wire pin_group_ok = (pin_group < GRP_W'(NUM_GROUPS));
  wire [GRP_W-1:0] group_nxt = group_inputs_used ? (pin_group_ok ? pin_group : group_r)
                             : (group_cmd && group_cmd_value < GRP_W'(NUM_GROUPS))
                               ? group_cmd_value : group_r;
  always_ff @(posedge mclk)
  begin
    if (srst) group_r <= RESET_GROUP;
    else group_r <= group_nxt;
  end
  assign active_group = group_r;

  // active group settings
  wire [5*ROW_W-1:0] g_trip = trip_mask[group_r*5*ROW_W +: 5*ROW_W];
  wire [4*ROW_W-1:0] g_a1 = aux1_mask[group_r*4*ROW_W +: 4*ROW_W];
  wire [4*ROW_W-1:0] g_a2 = aux2_mask[group_r*4*ROW_W +: 4*ROW_W];
  wire [4*ROW_W-1:0] g_a3 = aux3_mask[group_r*4*ROW_W +: 4*ROW_W];
  wire [4*ROW_W-1:0] g_a4 = aux4_mask[group_r*4*ROW_W +: 4*ROW_W];
  wire [4*ROW_W-1:0] g_rc = cancel_mask[group_r*4*ROW_W +: 4*ROW_W];
  wire [ROW_W-1:0] g_seq = step_mask[group_r*ROW_W +: ROW_W];
  wire [SHOTS*TMR_W-1:0] g_oi = open_interval[group_r*SHOTS*TMR_W +: SHOTS*TMR_W];
  wire [TMR_W-1:0] g_ri = reset_interval[group_r*TMR_W +: TMR_W];
  wire [TMR_W-1:0] g_itt = instant_target_delay[group_r*TMR_W +: TMR_W];
  wire [TMR_W-1:0] g_cft = close_fail_time[group_r*TMR_W +: TMR_W];
  wire [4:0] g_shm = shot_mask[group_r*5 +: 5];
  wire [CUR_W-1:0] g_pp = phase_pickup[group_r*CUR_W +: CUR_W];
  wire [CUR_W-1:0] g_qp = negseq_pickup[group_r*CUR_W +: CUR_W];
  wire [CUR_W-1:0] g_np = residual_pickup[group_r*CUR_W +: CUR_W];

  // ========================================================================
  // output equations
  wire [4*ROW_W-1:0] rows_1234 = {row4, row3, row2, row1};
  wire [4*ROW_W-1:0] rows_1346 = {row6, row4, row3, row1};
  wire [4*ROW_W-1:0] rows_2346 = {row6, row4, row3, row2};
  wire [4*ROW_W-1:0] rows_1246 = {row6, row4, row2, row1};
  wire eq_trip = |({row6, row4, row2, row1} & g_trip[4*ROW_W-1:0]) ||
                 |(row1 & g_trip[5*ROW_W-1:4*ROW_W]);
  wire open_exec = open_cmd && open_cmd_enable;
  wire trip_now = eq_trip || direct_trip_input || open_exec;
  wire a4_logic = |(rows_2346 & g_a4);
  wire alarm_now = selftest_warn || selftest_fail;
  wire permit = permit_assigned ? autoclose_permit_input : 1'b1;
  wire oc_any = |row1;
  wire seq_now = |(row1 & g_seq);
  wire rc_term = |(rows_1246 & g_rc);
  logic auto_close;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      trip_output <= 1'b0;
      close_output <= 1'b0;
      aux_output_1 <= 1'b0;
      aux_output_2 <= 1'b0;
      aux_output_3 <= 1'b0;
      aux_output_4 <= 1'b0;
      alarm_output <= 1'b0;
    end
    else
    begin
      trip_output <= trip_now;
      close_output <= (auto_close && permit) || direct_close_input || close_cmd;
      aux_output_1 <= |(rows_1234 & g_a1);
      aux_output_2 <= |(rows_1234 & g_a2);
      aux_output_3 <= |(rows_1346 & g_a3);
      aux_output_4 <= aux4_alarm_mode[group_r] ? alarm_now : a4_logic;
      alarm_output <= alarm_now;
    end
  end

  // ========================================================================
  // common cycle tick and timers
  logic [TICK_W-1:0] tick_cnt_r;
  wire tick = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));
  always_ff @(posedge mclk)
  begin
    if (srst || tick) tick_cnt_r <= '0;
    else tick_cnt_r <= tick_cnt_r + 1'b1;
  end

  // overcurrent duration before trip, for the close-in target
  logic [TMR_W-1:0] oc_time_r;
  always_ff @(posedge mclk)
  begin
    if (srst || !oc_any) oc_time_r <= '0;
    else if (tick && oc_time_r != '1) oc_time_r <= oc_time_r + 1'b1;
  end

  // ========================================================================
  // targets latched on the trip rising edge
  wire trip_rise = trip_now && !trip_output;
  always_ff @(posedge mclk)
  begin
    // a trip in the same cycle as a target reset wins, so no trip goes unrecorded
    if (srst || (target_reset_cmd && !trip_rise))
    begin
      close_in_fault_lamp <= 1'b0;
      phase_lamp <= 3'h0;
      negseq_lamp <= 1'b0;
      residual_lamp <= 1'b0;
    end
    else if (trip_rise)
    begin
      close_in_fault_lamp <= (oc_time_r <= g_itt);
      phase_lamp <= {ic > g_pp, ib > g_pp, ia > g_pp};
      negseq_lamp <= (i_negseq > g_qp);
      residual_lamp <= (i_residual > g_np);
    end
  end

  // ========================================================================
  // reclosing state machine
  frc_state_type state_r;
  logic [2:0] shot_r;
  logic [TMR_W-1:0] timer_r;
  logic seq_r;
  logic close_fail_r;
  wire breaker_closed = breaker_aux_status;
  wire [TMR_W-1:0] cur_oi = (shot_r < 3'h4) ? g_oi[shot_r[1:0]*TMR_W +: TMR_W] : '0;
  wire shots_left = (shot_r < 3'h4) && (cur_oi != '0);
  wire cancel = rc_term || !permit || direct_trip_input || close_fail_r || open_exec;
  wire seq_step = seq_r && !seq_now && !trip_output && breaker_closed && shot_r < 3'h4;
  wire trip_fall = !trip_now && trip_output;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_r <= RC_LOCKOUT;
      shot_r <= SHOT_NONE;
      timer_r <= '0;
      seq_r <= 1'b0;
      close_fail_r <= 1'b0;
    end
    else
    begin
      seq_r <= seq_now;
      close_fail_r <= 1'b0;
      if (!permit) state_r <= RC_LOCKOUT;
      else
        unique case (state_r)
          RC_RESET:
          begin
            shot_r <= seq_step ? shot_r + 1'b1 : SHOT_NONE;
            if (seq_step)
            begin
              state_r <= RC_CLOSING;
              timer_r <= '0;
            end
            else if (cancel) state_r <= RC_LOCKOUT;
            else if (trip_fall)
            begin
              state_r <= shots_left ? RC_OPEN : RC_LOCKOUT;
              timer_r <= '0;
            end
          end
          RC_OPEN:
            if (cancel) state_r <= RC_LOCKOUT;
            else if (timer_r >= cur_oi)
            begin
              state_r <= RC_CLOSING;
              shot_r <= shot_r + 1'b1;
              timer_r <= '0;
            end
            else if (tick) timer_r <= timer_r + 1'b1;
          RC_CLOSING:
            if (cancel) state_r <= RC_LOCKOUT;
            else if (trip_fall && breaker_closed) state_r <= RC_LOCKOUT;
            else if (trip_fall)
            begin
              state_r <= shots_left ? RC_OPEN : RC_LOCKOUT;
              timer_r <= '0;
            end
            else if (seq_step) shot_r <= shot_r + 1'b1;
            else if (!breaker_closed && timer_r >= g_cft && !trip_output)
              close_fail_r <= 1'b1;
            else if (oc_any || trip_output || !breaker_closed)
            begin
              if (breaker_closed) timer_r <= '0;
              else if (tick) timer_r <= timer_r + 1'b1;
            end
            else if (timer_r >= g_ri)
            begin
              state_r <= RC_RESET;
              shot_r <= SHOT_NONE;
            end
            else if (tick) timer_r <= timer_r + 1'b1;
          RC_LOCKOUT:
            if (breaker_closed && !trip_output && !oc_any)
            begin
              if (timer_r >= g_ri)
              begin
                state_r <= RC_RESET;
                shot_r <= SHOT_NONE;
              end
              else if (tick) timer_r <= timer_r + 1'b1;
            end
            else timer_r <= '0;
        endcase
    end
  end

  // automatic close is asserted in the closing state while the breaker is open, untripped and before the close-fail time
  assign auto_close = (state_r == RC_CLOSING) && !breaker_closed && timer_r < g_cft
                      && !trip_output;
  assign reset_state_lamp = (state_r == RC_RESET);
  assign held_open_lamp = (state_r == RC_LOCKOUT);
  assign cycling_state_bit = !reset_state_lamp && !held_open_lamp;
  assign final_open_state_bit = held_open_lamp;
  assign shot_flag_bit = g_shm[3'h4 - shot_r];
  assign shot_count = shot_r;
  assign close_fail = close_fail_r;

  // ========================================================================
  // breaker monitor
  logic breaker_q_r;
  wire breaker_open_edge = breaker_q_r && !breaker_aux_status;
  wire [3*CUR_W-1:0] cur_vec = {ic, ib, ia};
  always_ff @(posedge mclk)
  begin
    if (srst) breaker_q_r <= 1'b0;
    else breaker_q_r <= breaker_aux_status;
  end
  always_ff @(posedge mclk)
  begin
    if (srst || breaker_reset_cmd)
    begin
      relay_trip_count <= '0;
      ext_trip_count <= '0;
      relay_current_sum <= '0;
      ext_current_sum <= '0;
    end
    else if (trip_rise)
    begin
      relay_trip_count <= relay_trip_count + 1'b1;
      for (int p = 0; p < 3; p++)
        relay_current_sum[p*SUM_W +: SUM_W] <= relay_current_sum[p*SUM_W +: SUM_W]
          + SUM_W'(cur_vec[p*CUR_W +: CUR_W]);
    end
    else if (breaker_open_edge && !trip_output)
    begin
      ext_trip_count <= ext_trip_count + 1'b1;
      for (int p = 0; p < 3; p++)
        ext_current_sum[p*SUM_W +: SUM_W] <= ext_current_sum[p*SUM_W +: SUM_W]
          + SUM_W'(cur_vec[p*CUR_W +: CUR_W]);
    end
  end

endmodule
`default_nettype wire

// ---- src/frc_pkg.sv ----
// constants and types shared by the feeder reclose output logic
`default_nettype none
package frc_pkg;
  // element word rows and selection masks
  localparam int ROW_W = 16;
  localparam int NUM_GROUPS = 6;
  localparam int GRP_W = 3;
  localparam int SHOTS = 4;
  localparam int CUR_W = 16;
  localparam int SUM_W = 32;
  localparam int CNT_W = 16;
  localparam int TMR_W = 16;
  // tick rate: one power-system cycle at 60 hz from the 25 mhz clock
  localparam int CLK_HZ = 25000000;
  localparam int SYS_HZ = 60;
  localparam int TICK_CYCLES = CLK_HZ / SYS_HZ;
  localparam int TICK_W = 19;
  localparam logic [2:0] RESET_GROUP = 3'h0;
  localparam logic [2:0] SHOT_NONE = 3'h0;
  typedef enum logic [1:0]
  {
    RC_RESET = 2'b00,
    RC_OPEN = 2'b01,
    RC_CLOSING = 2'b10,
    RC_LOCKOUT = 2'b11
  } frc_state_type;
endpackage
`default_nettype wire

// ---- verification/frc_breaker_model.sv ----
// circuit breaker model driven by the trip and close coils
`default_nettype none
module frc_breaker_model
(
  // clock
  input wire logic mclk,
  // coils and a forced external opening
  input wire logic trip_coil,
  input wire logic close_coil,
  input wire logic force_open,
  // auxiliary contact, high while closed
  output var logic closed
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] trip_sr = 2'b00;
  logic [1:0] close_sr = 2'b00;
  initial closed = 1'b1;
  // two-edge mechanism delay: a held trip is still up when the poles part
  always @(posedge mclk)
  begin
    trip_sr <= {trip_sr[0], trip_coil};
    close_sr <= {close_sr[0], close_coil};
    if (force_open || trip_sr[1])
      closed <= #1 1'b0;
    else if (close_sr[1])
      closed <= #1 1'b1;
  end
endmodule
`default_nettype wire

// ---- verification/frc_reclose_asserts.sv ----
// port-level checks on the feeder reclose output logic
`default_nettype none
module frc_reclose_asserts
  import frc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // control inputs
  input wire logic direct_trip_input,
  input wire logic direct_close_input,
  input wire logic autoclose_permit_input,
  input wire logic permit_assigned,
  input wire logic selftest_warn,
  input wire logic selftest_fail,
  input wire logic breaker_reset_cmd,
  input wire logic [NUM_GROUPS*5-1:0] shot_mask,
  // watched outputs
  input wire logic trip_output,
  input wire logic close_output,
  input wire logic alarm_output,
  input wire logic reset_state_lamp,
  input wire logic held_open_lamp,
  input wire logic cycling_state_bit,
  input wire logic final_open_state_bit,
  input wire logic shot_flag_bit,
  input wire logic [2:0] shot_count,
  input wire logic [GRP_W-1:0] active_group,
  input wire logic [CNT_W-1:0] relay_trip_count,
  input wire logic [CNT_W-1:0] ext_trip_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (srst);
  // ==========================================================================
  // contacts and states
  dtrip_gives_trip_a: assert property (direct_trip_input |=> trip_output)
    else $error("trip missed after direct trip");
  dclose_gives_close_a: assert property (direct_close_input |=> close_output)
    else $error("close missed after direct close");
  alarm_follows_test_a: assert property
    (1'b1 |=> alarm_output == $past(selftest_warn | selftest_fail))
    else $error("alarm does not follow self-test");
  state_one_hot_a: assert property
    ($onehot({reset_state_lamp, cycling_state_bit, held_open_lamp}))
    else $error("reclose state bits not one-hot");
  lockout_lamp_a: assert property (held_open_lamp == final_open_state_bit)
    else $error("lockout lamp disagrees with lockout bit");
  permit_lockout_a: assert property
    (permit_assigned && !autoclose_permit_input |-> ##[1:2] final_open_state_bit)
    else $error("permit off did not lock out");
  shot_flag_a: assert property (active_group < 3'h6 && shot_count <= 3'h4 |->
    shot_flag_bit == shot_mask[int'(active_group) * 5 + 4 - int'(shot_count)])
    else $error("shot flag disagrees with mask");
  // ==========================================================================
  // breaker monitor
  count_steps_a: assert property (relay_trip_count != $past(relay_trip_count) |->
    relay_trip_count == $past(relay_trip_count) + 16'h1 || relay_trip_count == 16'h0)
    else $error("relay trip count jumped");
  count_clear_a: assert property
    (breaker_reset_cmd |=> relay_trip_count == 16'h0 && ext_trip_count == 16'h0)
    else $error("trip counts not cleared");
  trip_seen_c: cover property ($rose(trip_output));
  cycle_seen_c: cover property ($rose(cycling_state_bit));
  alarm_seen_c: cover property ($rose(alarm_output));
endmodule
bind frc_feeder_reclose frc_reclose_asserts frc_reclose_asserts_close_in_fault_lamp (.*);
`default_nettype wire

// ---- verification/test_frc_feeder_reclose.sv ----
// self-checking bench for the feeder reclose output logic
`default_nettype none
module test_frc_feeder_reclose;
  timeunit 1ns;
  timeprecision 1ps;
  import frc_pkg::*;
  // ==========================================================================
  // signals
  logic mclk, srst, ext_open;
  logic [ROW_W-1:0] row1, row2, row3, row4, row6;
  logic [NUM_GROUPS*5*ROW_W-1:0] trip_mask;
  logic [NUM_GROUPS*4*ROW_W-1:0] aux1_mask, aux2_mask, aux3_mask, aux4_mask, cancel_mask;
  logic [NUM_GROUPS*ROW_W-1:0] step_mask;
  logic [NUM_GROUPS-1:0] aux4_alarm_mode;
  logic [NUM_GROUPS*SHOTS*TMR_W-1:0] open_interval;
  logic [NUM_GROUPS*TMR_W-1:0] reset_interval, instant_target_delay, close_fail_time;
  logic [NUM_GROUPS*5-1:0] shot_mask;
  logic [NUM_GROUPS*CUR_W-1:0] phase_pickup, negseq_pickup, residual_pickup;
  logic [CUR_W-1:0] ia, ib, ic, i_negseq, i_residual;
  logic direct_trip_input, direct_close_input, autoclose_permit_input, permit_assigned;
  logic group_cmd, open_cmd, open_cmd_enable, close_cmd, target_reset_cmd, breaker_reset_cmd;
  logic selftest_warn, selftest_fail, breaker_aux_status;
  logic group_select_1, group_select_2, group_select_3, group_inputs_used;
  logic [GRP_W-1:0] group_cmd_value, active_group;
  logic trip_output, close_output, aux_output_1, aux_output_2, aux_output_3, aux_output_4;
  logic alarm_output, close_in_fault_lamp, negseq_lamp, residual_lamp, reset_state_lamp;
  logic held_open_lamp, cycling_state_bit, final_open_state_bit, shot_flag_bit, close_fail;
  logic [2:0] phase_lamp, shot_count;
  logic [CNT_W-1:0] relay_trip_count, ext_trip_count;
  logic [3*SUM_W-1:0] relay_current_sum, ext_current_sum;
  logic [4:0] contacts;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  // {trip, aux1, aux2, aux3, aux4} per row 1, 2, 3, 4, 6 with bit 0 of the row driven and selected
  localparam logic [4:0] CONTACT_EXP [5] = '{5'h1e, 5'h1d, 5'h0f, 5'h1f, 5'h13};
  localparam logic [95:0] CUR_SUM = {32'h0000_0300, 32'h0000_0050, 32'h0000_0200};
  assign contacts = {trip_output, aux_output_1, aux_output_2, aux_output_3, aux_output_4};
  frc_feeder_reclose frc_feeder_reclose_close_in_fault_lamp (.*);
  frc_breaker_model frc_breaker_model_close_in_fault_lamp (.mclk(mclk), .trip_coil(trip_output),
    .close_coil(close_output), .force_open(ext_open), .closed(breaker_aux_status));
  always #20 mclk = ~mclk;
  // ==========================================================================
  // helpers
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic [95:0] got, input logic [95:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic close_breaker;
    close_cmd = 1'b1;
    step(1);
    close_cmd = 1'b0;
    step(4);
  endtask
  task automatic give_verdict;
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      $display("BAD %0t run hung", $time);
      give_verdict();
    end
  end
  // ==========================================================================
  // sequence
  initial
  begin
    {mclk, srst, ext_open, autoclose_permit_input} = 4'h5;
    {row1, row2, row3, row4, row6, ia, ib, ic, i_negseq, i_residual} = '0;
    {direct_trip_input, direct_close_input, permit_assigned, group_cmd, open_cmd} = '0;
    {open_cmd_enable, close_cmd, target_reset_cmd, breaker_reset_cmd} = '0;
    {group_select_1, group_select_2, group_select_3, group_inputs_used} = '0;
    {selftest_warn, selftest_fail, aux4_alarm_mode, group_cmd_value} = '0;
    {trip_mask, aux1_mask, aux2_mask, aux3_mask, aux4_mask, cancel_mask, step_mask} = '0;
    {open_interval, reset_interval, instant_target_delay, close_fail_time} = '0;
    // row 1 bit 5 is kept out of trip and cancel so that it steps the shot counter without a trip
    trip_mask[79:0] = {16'hffdf, 64'hffff_ffff_ffff_ffdf};
    cancel_mask[63:0] = 64'hffff_ffff_ffff_ffdf;
    {aux1_mask[63:0], aux2_mask[63:0], aux3_mask[63:0], aux4_mask[63:0]} = '1;
    step_mask[15:0] = 16'h0020;
    instant_target_delay[15:0] = 16'h0001;
    close_fail_time[15:0] = 16'h0005;
    shot_mask = 30'h0000_0008;
    {phase_pickup, negseq_pickup, residual_pickup} = {18{16'h0100}};
    step(20);
    check({held_open_lamp, final_open_state_bit}, 2'b11, "reset lockout");
    check({contacts, shot_count, active_group}, 11'h0, "reset outputs");
    srst = 1'b0;
    step(2);
    for (int r = 0; r < 5; r++)
    begin
      {row6, row4, row3, row2, row1} = 80'h1 << (16 * r);
      step(1);
      check(contacts, CONTACT_EXP[r], "contacts for row");
      {row6, row4, row3, row2, row1} = '0;
      step(3);
    end
    selftest_warn = 1'b1;
    step(1);
    check({alarm_output, aux_output_4}, 2'b10, "warning alarm");
    {selftest_warn, selftest_fail, aux4_alarm_mode[0]} = 3'b011;
    step(1);
    check({alarm_output, aux_output_4}, 2'b11, "failure alarm on aux 4");
    {selftest_fail, aux4_alarm_mode[0]} = 2'b00;
    step(1);
    check({alarm_output, aux_output_4}, 2'b00, "alarm clear");
    direct_trip_input = 1'b1;
    step(1);
    check(trip_output, 1'b1, "direct trip");
    {direct_trip_input, open_cmd, open_cmd_enable} = 3'b011;
    step(1);
    check(trip_output, 1'b1, "open command");
    {open_cmd, open_cmd_enable} = 2'b00;
    step(3);
    direct_close_input = 1'b1;
    step(1);
    check(close_output, 1'b1, "direct close");
    direct_close_input = 1'b0;
    step(4);
    breaker_reset_cmd = 1'b1;
    step(1);
    check({relay_trip_count, ext_trip_count}, 32'h0, "counts cleared");
    breaker_reset_cmd = 1'b0;
    {ia, ib, ic, i_negseq, i_residual} = 80'h0200_0050_0300_0101_0010;
    row1 = 16'h0001;
    step(4);
    row1 = 16'h0000;
    step(3);
    check({close_in_fault_lamp, phase_lamp}, 4'hd, "close-in and phase targets");
    check({negseq_lamp, residual_lamp}, 2'b10, "sequence targets");
    check({relay_trip_count, ext_trip_count}, 32'h0001_0000, "relay trip count");
    check(relay_current_sum, CUR_SUM, "relay current sums");
    target_reset_cmd = 1'b1;
    step(1);
    target_reset_cmd = 1'b0;
    close_breaker();
    ext_open = 1'b1;
    step(1);
    ext_open = 1'b0;
    step(3);
    check({relay_trip_count, ext_trip_count}, 32'h0001_0001, "external trip count");
    check(ext_current_sum, CUR_SUM, "external current sums");
    breaker_reset_cmd = 1'b1;
    step(1);
    check(ext_current_sum, 96'h0, "sums cleared");
    breaker_reset_cmd = 1'b0;
    close_breaker();
    permit_assigned = 1'b1;
    autoclose_permit_input = 1'b0;
    step(3);
    check({final_open_state_bit, held_open_lamp}, 2'b11, "permit off");
    permit_assigned = 1'b0;
    for (int i = 0; i < 40 && reset_state_lamp !== 1'b1; i++)
      step(1);
    check({reset_state_lamp, held_open_lamp, shot_flag_bit}, 3'b100, "unassigned");
    reset_interval[15:0] = 16'h0001;
    row1 = 16'h0020;
    step(2);
    row1 = 16'h0000;
    step(3);
    check({shot_count, cycling_state_bit, shot_flag_bit}, 5'b00111, "seq step");
    direct_trip_input = 1'b1;
    step(1);
    direct_trip_input = 1'b0;
    step(3);
    check({held_open_lamp, cycling_state_bit}, 2'b10, "cancel to lockout");
    // zero close-fail time: a breaker that opens during the cycle is a close failure
    {reset_interval[15:0], close_fail_time[15:0]} = '0;
    close_breaker();
    {reset_interval[15:0], row1} = {16'h0001, 16'h0020};
    step(2);
    row1 = 16'h0000;
    step(1);
    ext_open = 1'b1;
    step(1);
    ext_open = 1'b0;
    step(1);
    check(close_fail, 1'b1, "close fail");
    step(1);
    check({close_fail, held_open_lamp}, 2'b01, "close fail lockout");
    group_cmd_value = 3'h5;
    group_cmd = 1'b1;
    step(1);
    group_cmd = 1'b0;
    row2 = 16'h0001;
    step(2);
    check({active_group, trip_output}, 4'ha, "group five logic");
    {group_inputs_used, group_select_3, group_select_2, group_select_1} = 4'hb;
    step(1);
    check(active_group, 3'h3, "pin group select");
    {group_select_3, group_select_2, group_select_1} = 3'h6;
    step(1);
    check(active_group, 3'h3, "pin code six held");
    {group_select_3, group_select_2, group_select_1} = 3'h0;
    step(2);
    check({active_group, trip_output}, 4'h1, "pin group zero logic");
    give_verdict();
  end
endmodule
`default_nettype wire
